/* ocp_params.svh */
`ifndef OCP_PARAMS_SVH
`define OCP_PARAMS_SVH

// register byte offsets
`define OCP_OFS_CTRL      8'h00
`define OCP_OFS_PRIMARY   8'h04
`define OCP_OFS_SECONDARY 8'h08
`define OCP_OFS_IRQ_STAT  8'h0C
`define OCP_OFS_IRQ_MASK  8'h10

// control field positions
`define OCP_BIT_ON        15
`define OCP_BIT_IDLE_STOP 13
`define OCP_BIT_WIDE      5
`define OCP_BIT_FAULT     4
`define OCP_BIT_TSEL      3
`define OCP_MODE_HI       2
`define OCP_MODE_LO       0

// writable control bits; everything else reads zero except the fault flag at bit 4
`define OCP_CTRL_WMASK    32'h0000_A02F
`define OCP_CTRL_RESET    32'h0000_0000

// interrupt status layout
`define OCP_IRQ_COMPARE   0
`define OCP_IRQ_FAULT     1
`define OCP_IRQ_BITS      2

// narrow compare width
`define OCP_NARROW_W      16

`endif

/* ocp_pkg.sv */
package ocp_pkg;

	typedef enum logic [2:0] {
		OCP_MODE_OFF    = 3'h0,
		OCP_MODE_SET    = 3'h1,
		OCP_MODE_CLR    = 3'h2,
		OCP_MODE_TOGGLE = 3'h3,
		OCP_MODE_SINGLE = 3'h4,
		OCP_MODE_TRAIN  = 3'h5,
		OCP_MODE_PWM    = 3'h6,
		OCP_MODE_PWM_FLT = 3'h7
	} ocp_mode_e;

	// single pulse sequence, gray coded along the path
	typedef enum logic [1:0] {
		OCP_PS_ARMED = 2'h0,
		OCP_PS_HIGH  = 2'h1,
		OCP_PS_DONE  = 2'h3
	} ocp_pulse_e;

endpackage

/* ocp_sync.sv */
`timescale 1ns/1ps
module ocp_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// asynchronous level in, synchronous level out
	input  wire logic async_i,
	output logic      sync_o
);
	logic meta;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta   <= RESET_VAL;
			sync_o <= RESET_VAL;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule // ocp_sync

/* ocp_match.sv */
`timescale 1ns/1ps
`include "ocp_params.svh"
module ocp_match #(
	parameter int W = 32
) (
	// operands
	input  wire logic [W-1:0] count_i,
	input  wire logic [W-1:0] value_i,
	input  wire logic         wide_i,
	// equality at the selected width
	output logic              equal_o
);
	wire logic low_eq;
	wire logic high_eq;

	assign low_eq  = count_i[`OCP_NARROW_W-1:0] == value_i[`OCP_NARROW_W-1:0];
	assign high_eq = count_i[W-1:`OCP_NARROW_W] == value_i[W-1:`OCP_NARROW_W];
	assign equal_o = low_eq && (high_eq || !wide_i);
endmodule // ocp_match

/* ocp_top.sv */
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ocp_params.svh"
module ocp_top #(
	parameter int CW = 32
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// wishbone slave
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	// time bases and system state
	input  wire logic [CW-1:0] timer_first_i,
	input  wire logic [CW-1:0] timer_second_i,
	input  wire logic          cpu_idle_i,
	// pins
	input  wire logic          fault_n_i,
	output logic               compare_output_pin_o,
	output logic               irq_o
);
	// registers
	logic [31:0]                ctrl;
	logic [CW-1:0]              primary_compare_value;
	logic [CW-1:0]              secondary_compare_value;
	logic [CW-1:0]              duty;
	logic [`OCP_IRQ_BITS-1:0]   irq_stat;
	logic [`OCP_IRQ_BITS-1:0]   irq_mask;
	logic                       pwm_fault_flag;
	logic [2:0]                 mode_q;
	logic                       on_q;
	ocp_pkg::ocp_pulse_e        pulse_st;

	// combinational
	logic                       next_pin;
	ocp_pkg::ocp_pulse_e        next_pulse_st;
	logic [31:0]                next_dat;

	wire logic                  fault_sync_n;
	wire logic                  eq_primary;
	wire logic                  eq_secondary;
	wire logic                  eq_duty;

	// control fields
	wire logic                  unit_on = ctrl[`OCP_BIT_ON];
	wire logic                  idle_stop = ctrl[`OCP_BIT_IDLE_STOP];
	wire logic                  wide_compare_select = ctrl[`OCP_BIT_WIDE];
	wire logic                  timer_source_select = ctrl[`OCP_BIT_TSEL];
	wire ocp_pkg::ocp_mode_e    compare_mode_field =
		ocp_pkg::ocp_mode_e'(ctrl[`OCP_MODE_HI:`OCP_MODE_LO]);

	// bus decode
	wire logic                  bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic                  bus_wr = bus_req && wb_we_i;
	wire logic                  hit_ctrl = wb_adr_i == `OCP_OFS_CTRL;
	wire logic                  hit_pri = wb_adr_i == `OCP_OFS_PRIMARY;
	wire logic                  hit_sec = wb_adr_i == `OCP_OFS_SECONDARY;
	wire logic                  hit_stat = wb_adr_i == `OCP_OFS_IRQ_STAT;
	wire logic                  hit_mask = wb_adr_i == `OCP_OFS_IRQ_MASK;
	wire logic [31:0]           lane_mask = {{8{wb_sel_i[3]}},
		{8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// the unit advances only when on and not parked by idle
	wire logic                  running = unit_on
		&& !(idle_stop && cpu_idle_i);
	wire logic [CW-1:0]         count = timer_source_select
		? timer_second_i : timer_first_i;
	wire logic                  count_zero = count == '0;
	wire logic                  is_pwm = compare_mode_field[2:1] == 2'b11;
	wire logic                  fault_mode =
		compare_mode_field == ocp_pkg::OCP_MODE_PWM_FLT;
	wire logic                  fault_act = fault_mode && !fault_sync_n;
	wire logic                  entry = unit_on
		&& (!on_q || mode_q != compare_mode_field);
	wire logic                  evt_p = running && eq_primary;
	wire logic                  evt_s = running && eq_secondary;
	wire logic                  duty_zero =
		wide_compare_select ? secondary_compare_value == '0
		: secondary_compare_value[`OCP_NARROW_W-1:0] == '0;
	wire logic                  cmp_event = is_pwm
		? running && eq_duty && !count_zero
		: evt_p && compare_mode_field != ocp_pkg::OCP_MODE_OFF;
	wire logic                  fault_clear = on_q && !fault_sync_n == 1'b0
		&& running && count_zero;

	// read view: unimplemented bits forced to zero
	wire logic [31:0]           ctrl_view = (ctrl & `OCP_CTRL_WMASK)
		| ({31'h0000_0000, pwm_fault_flag && fault_mode}
		<< `OCP_BIT_FAULT);
	wire logic [31:0]           irq_write = wb_dat_i & lane_mask;

	ocp_sync #(
		.RESET_VAL(1'b1)
	) u_fault_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.async_i(fault_n_i),
		.sync_o (fault_sync_n)
	);

	ocp_match #(.W(CW)) u_match_primary (
		.count_i(count),
		.value_i(primary_compare_value),
		.wide_i (wide_compare_select),
		.equal_o(eq_primary)
	);

	ocp_match #(.W(CW)) u_match_secondary (
		.count_i(count),
		.value_i(secondary_compare_value),
		.wide_i (wide_compare_select),
		.equal_o(eq_secondary)
	);

	ocp_match #(.W(CW)) u_match_duty (
		.count_i(count),
		.value_i(duty),
		.wide_i (wide_compare_select),
		.equal_o(eq_duty)
	);

	always_comb begin
		next_pin = compare_output_pin_o;
		next_pulse_st = pulse_st;
		if (!unit_on) begin
			next_pin = 1'b0;
			next_pulse_st = ocp_pkg::OCP_PS_ARMED;
		end else if (entry) begin
			// every mode starts from its defined initial level
			next_pin = compare_mode_field == ocp_pkg::OCP_MODE_CLR;
			next_pulse_st = ocp_pkg::OCP_PS_ARMED;
		end else if (running) begin
			case (compare_mode_field)
			ocp_pkg::OCP_MODE_OFF: next_pin = 1'b0;
			ocp_pkg::OCP_MODE_SET: if (evt_p) next_pin = 1'b1;
			ocp_pkg::OCP_MODE_CLR: if (evt_p) next_pin = 1'b0;
			ocp_pkg::OCP_MODE_TOGGLE: begin
				if (evt_p) next_pin = !compare_output_pin_o;
			end
			ocp_pkg::OCP_MODE_SINGLE: begin
				case (pulse_st)
				ocp_pkg::OCP_PS_ARMED: begin
					if (evt_p) begin
						next_pin = 1'b1;
						next_pulse_st = ocp_pkg::OCP_PS_HIGH;
					end
				end
				ocp_pkg::OCP_PS_HIGH: begin
					if (evt_s) begin
						next_pin = 1'b0;
						next_pulse_st = ocp_pkg::OCP_PS_DONE;
					end
				end
				default: next_pin = 1'b0;
				endcase
			end
			ocp_pkg::OCP_MODE_TRAIN: begin
				// secondary wins when both match: pulse of zero width
				if (evt_s) next_pin = 1'b0;
				else if (evt_p) next_pin = 1'b1;
			end
			default: begin
				// pwm: period starts at count zero, duty from secondary
				if (fault_act || pwm_fault_flag) next_pin = 1'b0;
				else if (count_zero) next_pin = !duty_zero;
				else if (eq_duty) next_pin = 1'b0;
			end
			endcase
		end
	end

	always_comb begin
		case (wb_adr_i)
		`OCP_OFS_CTRL:      next_dat = ctrl_view;
		`OCP_OFS_PRIMARY:   next_dat = 32'(primary_compare_value);
		`OCP_OFS_SECONDARY: next_dat = 32'(secondary_compare_value);
		`OCP_OFS_IRQ_STAT:  next_dat = 32'(irq_stat);
		`OCP_OFS_IRQ_MASK:  next_dat = 32'(irq_mask);
		default:            next_dat = 32'h0000_0000;
		endcase
	end

	// bus answer: one wait state, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req && !wb_we_i ? next_dat : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `OCP_CTRL_RESET;
			primary_compare_value <= '0;
			secondary_compare_value <= '0;
			irq_mask <= '0;
		end else if (bus_wr) begin
			if (hit_ctrl)
				ctrl <= (ctrl & ~lane_mask)
					| (wb_dat_i & lane_mask & `OCP_CTRL_WMASK);
			if (hit_pri)
				primary_compare_value <= CW'((primary_compare_value
					& ~CW'(lane_mask)) | CW'(wb_dat_i & lane_mask));
			if (hit_sec)
				secondary_compare_value <= CW'((secondary_compare_value
					& ~CW'(lane_mask)) | CW'(wb_dat_i & lane_mask));
			if (hit_mask)
				irq_mask <= irq_write[`OCP_IRQ_BITS-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			compare_output_pin_o <= 1'b0;
			pulse_st <= ocp_pkg::OCP_PS_ARMED;
			mode_q <= 3'h0;
			on_q <= 1'b0;
			duty <= '0;
		end else begin
			compare_output_pin_o <= next_pin;
			pulse_st <= next_pulse_st;
			mode_q <= compare_mode_field;
			on_q <= unit_on;
			// new duty only takes hold at a period start, so no glitch
			if (running && is_pwm && count_zero)
				duty <= secondary_compare_value;
		end
	end

	// fault flag: writing it does not clear it; a ctrl write leaving mode 111 or a period start with the fault gone does; set wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pwm_fault_flag <= 1'b0;
		else if (fault_act && unit_on)
			pwm_fault_flag <= 1'b1;
		else if (!fault_mode || (fault_sync_n && fault_clear))
			pwm_fault_flag <= 1'b0;
	end

	// sticky interrupt causes, write one to clear, set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= '0;
			irq_o <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~(bus_wr && hit_stat
				? irq_write[`OCP_IRQ_BITS-1:0] : '0))
				| {fault_act && unit_on && !pwm_fault_flag, cmp_event};
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	wire logic [CW-1:0] sel_cnt = count;

	property p_off_low;
		@(posedge clk_i) disable iff (rst_i)
		!unit_on |=> !compare_output_pin_o;
	endproperty
	a_off_low: assert property (p_off_low)
		else $error("pin not low while unit is off");

	property p_idle_hold;
		@(posedge clk_i) disable iff (rst_i)
		unit_on && idle_stop && cpu_idle_i && !entry
			|=> $stable(compare_output_pin_o);
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("pin moved while halted in idle");

	property p_narrow;
		@(posedge clk_i) disable iff (rst_i)
		evt_p && !wide_compare_select |->
			sel_cnt[15:0] == primary_compare_value[15:0];
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("narrow compare event on wrong value");

	property p_fault_set;
		@(posedge clk_i) disable iff (rst_i)
		unit_on && fault_mode && !fault_sync_n |=> pwm_fault_flag
			##0 !compare_output_pin_o;
	endproperty
	a_fault_set: assert property (p_fault_set)
		else $error("fault flag or pin wrong after fault");

	property p_flag_zero;
		@(posedge clk_i) disable iff (rst_i)
		bus_req && !wb_we_i && hit_ctrl && !fault_mode |=> !wb_dat_o[4];
	endproperty
	a_flag_zero: assert property (p_flag_zero)
		else $error("fault flag visible outside mode 111");

	property p_tsel;
		@(posedge clk_i) disable iff (rst_i)
		evt_p && timer_source_select |-> eq_primary
			&& timer_second_i[15:0] == primary_compare_value[15:0];
	endproperty
	a_tsel: assert property (p_tsel)
		else $error("event not from second timer");

	property p_toggle;
		@(posedge clk_i) disable iff (rst_i)
		running && !entry && evt_p
			&& compare_mode_field == ocp_pkg::OCP_MODE_TOGGLE
			|=> compare_output_pin_o != $past(compare_output_pin_o);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("toggle mode did not invert pin");

	property p_set_high;
		@(posedge clk_i) disable iff (rst_i)
		running && !entry && evt_p
			&& compare_mode_field == ocp_pkg::OCP_MODE_SET
			|=> compare_output_pin_o;
	endproperty
	a_set_high: assert property (p_set_high)
		else $error("set mode did not drive pin high");

	property p_init_high;
		@(posedge clk_i) disable iff (rst_i)
		entry && compare_mode_field == ocp_pkg::OCP_MODE_CLR
			|=> compare_output_pin_o;
	endproperty
	a_init_high: assert property (p_init_high)
		else $error("clear mode did not start high");

	property p_off_mode;
		@(posedge clk_i) disable iff (rst_i)
		compare_mode_field == ocp_pkg::OCP_MODE_OFF [*2]
			|=> !compare_output_pin_o;
	endproperty
	a_off_mode: assert property (p_off_mode)
		else $error("pin active in mode 000");

	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held for two cycles");

	c_single: cover property (@(posedge clk_i) disable iff (rst_i)
		pulse_st == ocp_pkg::OCP_PS_DONE);
	c_fault: cover property (@(posedge clk_i) disable iff (rst_i)
		pwm_fault_flag);
	c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
endmodule // ocp_top

/* ocp_load_model.sv */
`timescale 1ns/1ps
module ocp_load_model (
	// clock
	input  wire logic       clk_i,
	// compare pin and fault request from the bench
	input  wire logic       pin_i,
	input  wire logic       fault_req_i,
	// fault line and count of rising pin edges seen by the load
	output logic            fault_n_o,
	output logic [7:0]      rise_cnt_o
);
	logic       pin_q = 1'b0;
	logic [7:0] rise_cnt = 8'h00;

	// open drain with pull-up: a released line reads high
	assign fault_n_o = fault_req_i ? 1'b0 : 1'b1;
	assign rise_cnt_o = rise_cnt;

	always @(posedge clk_i) begin
		pin_q <= pin_i;
		if (pin_i && !pin_q)
			rise_cnt <= rise_cnt + 8'h01;
	end
endmodule // ocp_load_model

/* ocp_top_tb_top.sv */
`timescale 1ns/1ps
`include "ocp_params.svh"
module ocp_top_tb_top;
	// timer value that never matches any programmed compare value
	localparam logic [31:0] IDLE_CNT = 32'h0000_7777;
	localparam logic [31:0] ON       = 32'h0000_8000;
	localparam logic [31:0] STOP_IDLE = 32'h0000_2000;
	localparam logic [31:0] WIDE     = 32'h0000_0020;
	localparam logic [31:0] TSEL     = 32'h0000_0008;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic [31:0] tmr [2];
	logic        idle;
	logic        fault_n;
	logic        fault_req;
	logic        pin;
	logic        irq;
	logic [7:0]  rises;
	logic [7:0]  r0;
	logic [31:0] q;
	int          n_mismatch;
	int          num_checks;
	int          cycles;

	ocp_top #(.CW(32)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .timer_first_i(tmr[0]),
		.timer_second_i(tmr[1]), .cpu_idle_i(idle), .fault_n_i(fault_n),
		.compare_output_pin_o(pin), .irq_o(irq));

	ocp_load_model load (.clk_i(clk_i), .pin_i(pin),
		.fault_req_i(fault_req), .fault_n_o(fault_n), .rise_cnt_o(rises));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one classic cycle; waits for ack however long it takes
	task automatic wb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0000_0000);
		check(q, exp);
	endtask

	// mode entry needs settling edges before matches count
	task automatic cfg(input logic [31:0] c);
		wb(1'b1, `OCP_OFS_CTRL, c);
		repeat (3) @(posedge clk_i);
	endtask

	// one matching cycle on a timer, then look at the pin it produced
	task automatic hit(input int s, input logic [31:0] v, input logic e);
		@(posedge clk_i);
		tmr[s] <= v;
		@(posedge clk_i);
		tmr[s] <= IDLE_CNT;
		@(posedge clk_i);
		check({31'h0, pin}, {31'h0, e});
	endtask

	task automatic t_regs();
		rd_chk(`OCP_OFS_CTRL, 32'h0000_0000);
		wb(1'b1, `OCP_OFS_CTRL, 32'hFFFF_FFFF);
		rd_chk(`OCP_OFS_CTRL, 32'h0000_A02F);
		rd_chk(8'h40, 32'h0000_0000);
		wb(1'b1, `OCP_OFS_PRIMARY, 32'h0000_0005);
		wb(1'b1, `OCP_OFS_SECONDARY, 32'h0000_0009);
	endtask

	task automatic t_set_irq();
		cfg(ON | 32'h1);
		check({31'h0, pin}, 32'h0);
		hit(0, 32'h0000_0005, 1'b1);
		rd_chk(`OCP_OFS_IRQ_STAT, 32'h0000_0001);
		check({31'h0, irq}, 32'h0);
		wb(1'b1, `OCP_OFS_IRQ_MASK, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		check({31'h0, irq}, 32'h1);
		wb(1'b1, `OCP_OFS_IRQ_STAT, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		check({31'h0, irq}, 32'h0);
		wb(1'b1, `OCP_OFS_IRQ_MASK, 32'h0000_0000);
	endtask

	task automatic t_modes();
		cfg(ON | TSEL | 32'h2);
		check({31'h0, pin}, 32'h1);
		hit(0, 32'h0000_0005, 1'b1);
		hit(1, 32'h0000_0005, 1'b0);
		cfg(ON | 32'h3);
		hit(0, 32'h0000_0005, 1'b1);
		hit(0, 32'h0000_0005, 1'b0);
		cfg(ON | 32'h4);
		hit(0, 32'h0000_0005, 1'b1);
		hit(0, 32'h0000_0009, 1'b0);
		hit(0, 32'h0000_0005, 1'b0);
		cfg(ON | 32'h5);
		r0 = rises;
		hit(0, 32'h0000_0005, 1'b1);
		hit(0, 32'h0000_0009, 1'b0);
		hit(0, 32'h0000_0005, 1'b1);
		// the load counts a rise on the edge after the pin goes high
		@(posedge clk_i);
		check({24'h0, rises - r0}, 32'h2);
		cfg(ON);
		hit(0, 32'h0000_0005, 1'b0);
	endtask

	task automatic t_wide();
		wb(1'b1, `OCP_OFS_PRIMARY, 32'h0001_0005);
		cfg(ON | 32'h3);
		hit(0, 32'h0002_0005, 1'b1);
		// same mode code: no entry, so the pin keeps its high level
		cfg(ON | WIDE | 32'h3);
		hit(0, 32'h0002_0005, 1'b1);
		hit(0, 32'h0001_0005, 1'b0);
		wb(1'b1, `OCP_OFS_PRIMARY, 32'h0000_0005);
	endtask

	task automatic t_idle_off();
		cfg(ON | STOP_IDLE | 32'h1);
		idle <= 1'b1;
		hit(0, 32'h0000_0005, 1'b0);
		idle <= 1'b0;
		hit(0, 32'h0000_0005, 1'b1);
		// toggle entry starts low, so a halted unit would leave it low
		cfg(ON | 32'h3);
		idle <= 1'b1;
		hit(0, 32'h0000_0005, 1'b1);
		idle <= 1'b0;
		cfg(32'h0000_0001);
		check({31'h0, pin}, 32'h0);
		hit(0, 32'h0000_0005, 1'b0);
	endtask

	task automatic t_pwm();
		wb(1'b1, `OCP_OFS_SECONDARY, 32'h0000_0003);
		cfg(ON | 32'h6);
		hit(0, 32'h0000_0000, 1'b1);
		hit(0, 32'h0000_0003, 1'b0);
		fault_req <= 1'b1;
		hit(0, 32'h0000_0000, 1'b1);
		rd_chk(`OCP_OFS_CTRL, ON | 32'h6);
		fault_req <= 1'b0;
		cfg(ON | 32'h7);
		hit(0, 32'h0000_0000, 1'b1);
		fault_req <= 1'b1;
		repeat (5) @(posedge clk_i);
		check({31'h0, pin}, 32'h0);
		rd_chk(`OCP_OFS_CTRL, 32'h0000_8017);
		wb(1'b1, `OCP_OFS_CTRL, ON | 32'h7);
		rd_chk(`OCP_OFS_CTRL, 32'h0000_8017);
		wb(1'b0, `OCP_OFS_IRQ_STAT, 32'h0000_0000);
		check(q & 32'h2, 32'h2);
		fault_req <= 1'b0;
		cfg(ON | 32'h6);
		rd_chk(`OCP_OFS_CTRL, ON | 32'h6);
	endtask

	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0000_0000;
		tmr[0] = IDLE_CNT;
		tmr[1] = IDLE_CNT;
		idle = 1'b0;
		fault_req = 1'b0;
		n_mismatch = 0;
		num_checks = 0;
		cycles = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_set_irq();
		t_modes();
		t_wide();
		t_idle_off();
		t_pwm();
		end_of_test();
	end
endmodule // ocp_top_tb_top
